// ### src/parallel_flash_config_reader.sv
// master mode loader that fetches a configuration image from an x16 NOR flash
// assumes flash pins and the external clock are asynchronous to ref_clk
//What this block does
// - mode 010 selects; init, then release init-done
// - drive select, enables, incrementing address, capture data
// - read header first on internal clock
// - sync command triggers async read-config write
// - resume header only after that write completes
// - header chooses internal or external clock
// - external clock: burst read at its rate
// - flash left in synchronous read afterwards
// - restart on power cycle or restart low pulse
// - one sixteen-bit word per configuration clock
// - two sync type variants by setting
`timescale 1ns/1ps
`include "flash_cfg_defines.svh"
module parallel_flash_config_reader (
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    input  wire logic [2:0]                modePins,
    input  wire logic                      configRestartN,
    input  wire logic                      initDoneIn,
    output logic                           initDoneOut,
    output logic                           initDoneOe,
    input  wire logic                      syncTypeSel,
    input  wire logic                      externalMasterConfigClock,
    input  wire logic [15:0]               flashDataIn,
    output flash_cfg_pkg::flash_pins_t     flashPins,
    output logic                           internalConfigClock,
    output logic [15:0]                    imageData,
    output logic                           imageValid,
    input  wire logic                      imageReady,
    output logic                           extClockActive,
    output logic                           configDone,
    output logic                           configError
);
    import flash_cfg_pkg::*;

    typedef struct packed {
        cfg_state_t  st;        // sequence state
        logic [2:0]  modeS1;    // synchronisers, first stages
        logic [2:0]  modeS2;
        logic        rstS1;
        logic        rstS2;
        logic        initS1;
        logic        initS2;
        logic        emcS1;
        logic        emcS2;
        logic        emcS3;     // delayed copy for edge detect
        logic [15:0] dataS1;
        logic [15:0] dataS2;
        logic [7:0]  cnt;       // init wait
        logic [6:0]  divCnt;    // internal clock divider
        logic        iclk;      // internal clock level
        logic        initOe;    // holding init-done low
        logic [1:0]  hdrIdx;    // header word index
        logic [1:0]  phase;     // read config write phase
        logic        syncMode;  // flash set to burst read
        logic        extSel;    // header asked for external clock
        logic        extAct;    // running on external clock
        logic [3:0]  latCnt;    // burst latency skip
        logic [28:0] rdAddr;    // next word address
        logic [31:0] remain;    // data words still to read
        flash_pins_t pins;
    } cfg_regs_t;
    cfg_regs_t s, n;

    logic tickI;      // internal clock enable
    logic emcRise;    // external clock rising edge
    logic rdTick;     // read strobe of the active clock
    logic latOk;      // burst latency elapsed
    logic push;       // word to the FIFO
    logic fifoReady;  // FIFO can take a word

    // address increment shared by header and data reads
    function automatic logic [28:0] nextAddr(input logic [28:0] a);
        return a + 29'h1;
    endfunction

    assign tickI   = s.divCnt == 7'(`ICLK_DIV - 1);
    assign emcRise = s.emcS2 & ~s.emcS3;
    assign rdTick  = s.extAct ? emcRise : tickI;
    assign latOk   = !s.syncMode || (s.latCnt == `SYNC_LATENCY);
    assign push    = (s.st == ST_DATA) && rdTick && latOk && fifoReady;

    // next state of the loader
    always_comb begin
        n = s;
        n.modeS1 = modePins;
        n.modeS2 = s.modeS1;
        n.rstS1  = configRestartN;
        n.rstS2  = s.rstS1;
        n.initS1 = initDoneIn;
        n.initS2 = s.initS1;
        n.emcS1  = externalMasterConfigClock;
        n.emcS2  = s.emcS1;
        n.emcS3  = s.emcS2;
        n.dataS1 = flashDataIn;
        n.dataS2 = s.dataS1;
        // internal clock divider, half high, half low
        n.divCnt = tickI ? 7'h0 : s.divCnt + 7'h1;
        if (tickI || s.divCnt == 7'(`ICLK_DIV / 2 - 1)) begin
            n.iclk = ~s.iclk;
        end
        // burst clock: external once switched, else internal
        n.pins.clk = s.syncMode && (s.extAct ? s.emcS2 : s.iclk);
        // latency counted on the active clock after burst start
        if (s.syncMode && rdTick && !latOk) begin
            n.latCnt = s.latCnt + 4'h1;
        end
        case (s.st)
            ST_IDLE: begin
                // let the mode synchroniser settle first
                n.initOe = 1'b1;
                n.cnt    = s.cnt + 8'h1;
                if (s.cnt == 8'h3) begin
                    n.cnt = 8'h0;
                    n.st  = (s.modeS2 == `MODE_PAR_FLASH) ? ST_INIT : ST_FAIL;
                end
            end
            ST_INIT: begin
                if (s.cnt != 8'(`INIT_CYCLES - 1)) begin
                    n.cnt = s.cnt + 8'h1;
                end else begin
                    n.initOe = 1'b0;
                    // another party may still hold the line low
                    if (!s.initOe && s.initS2) begin
                        n.st              = ST_HDR;
                        n.cnt             = 8'h0;  // settle count for the first word
                        n.rdAddr          = 29'h0;
                        n.pins.addr       = 29'h0;
                        n.pins.chipSelN   = 1'b0;
                        n.pins.outEnN     = 1'b0;
                        n.pins.addrValidN = 1'b0;
                    end
                end
            end
            ST_HDR: begin
                // first header word on the internal clock; the divider phase is free,
                // so a tick right after the address appears would take a stale word
                if (s.cnt != 8'h3) begin
                    n.cnt = s.cnt + 8'h1;
                end
                if (tickI && s.cnt == 8'h3) begin
                    n.rdAddr    = nextAddr(s.rdAddr);
                    n.pins.addr = nextAddr(s.rdAddr);
                    n.hdrIdx    = 2'h0;
                    if (s.dataS2 == `HDR_SYNC_KEY) begin
                        n.st          = ST_RCR;
                        n.phase       = 2'h0;
                        n.pins.outEnN = 1'b1;
                    end else begin
                        n.st = ST_HDRX;
                    end
                end
            end
            ST_RCR: begin
                // two async write cycles, setup then confirm
                if (tickI) begin
                    n.phase = s.phase + 2'h1;
                    case (s.phase)
                        2'h0: begin
                            n.pins.addr     = syncTypeSel ? `RCR_TYPE2 : `RCR_TYPE1;
                            n.pins.dataOut  = `CMD_RCR_SETUP;
                            n.pins.dataOe   = 1'b1;
                            n.pins.writeEnN = 1'b0;
                        end
                        2'h1: n.pins.writeEnN = 1'b1;
                        2'h2: begin
                            n.pins.dataOut  = `CMD_RCR_CONFIRM;
                            n.pins.writeEnN = 1'b0;
                        end
                        default: begin
                            // write finished, back to header reading
                            n.pins.writeEnN = 1'b1;
                            n.pins.dataOe   = 1'b0;
                            n.pins.outEnN   = 1'b0;
                            n.pins.addr     = s.rdAddr;
                            n.syncMode      = 1'b1;
                            n.latCnt        = 4'h0;
                            n.st            = ST_HDRX;
                        end
                    endcase
                end
            end
            ST_HDRX: begin
                // clock select and image length, still internal clock
                if (tickI && latOk) begin
                    n.rdAddr    = nextAddr(s.rdAddr);
                    n.pins.addr = nextAddr(s.rdAddr);
                    n.hdrIdx    = s.hdrIdx + 2'h1;
                    case (s.hdrIdx)
                        2'h0: n.extSel = s.dataS2[`HDR_EXT_CLK_BIT];
                        2'h1: n.remain[31:16] = s.dataS2;
                        default: begin
                            n.remain[15:0] = s.dataS2;
                            // external clock only makes sense with burst reads
                            n.extAct = s.extSel && s.syncMode;
                            // fresh latency on the new clock: the data address is not settled yet
                            n.latCnt = 4'h0;
                            n.st = ({s.remain[31:16], s.dataS2} == 32'h0) ? ST_DONE : ST_DATA;
                        end
                    endcase
                end
            end
            ST_DATA: begin
                // a full FIFO stalls the read, the address holds
                if (push) begin
                    n.rdAddr    = nextAddr(s.rdAddr);
                    n.pins.addr = nextAddr(s.rdAddr);
                    n.remain    = s.remain - 32'h1;
                    if (s.remain == 32'h1) begin
                        n.st = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                // no write back to async mode, flash stays in burst read
                n.pins.chipSelN   = 1'b1;
                n.pins.outEnN     = 1'b1;
                n.pins.addrValidN = 1'b1;
            end
            default: begin
                // wrong mode pins: stay put, init-done held
                n.initOe = 1'b1;
            end
        endcase
        // a low restart pulse starts over from the top
        if (!s.rstS2) begin
            n.st     = ST_IDLE;
            n.cnt    = 8'h0;
            n.initOe = 1'b1;
            n.extAct = 1'b0;
            n.pins   = '{addr: 29'h0, dataOut: 16'h0, dataOe: 1'b0, clk: 1'b0,
                         default: 1'b1};
        end
    end

    // register the state; power cycle enters through srst
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s        <= '0;
            s.st     <= ST_IDLE;
            s.rstS1  <= 1'b1;
            s.rstS2  <= 1'b1;
            s.initOe <= 1'b1;
            s.pins   <= '{addr: 29'h0, dataOut: 16'h0, dataOe: 1'b0, clk: 1'b0,
                          default: 1'b1};
        end else begin
            s <= n;
        end
    end

    image_fifo #(.WIDTH(16), .DEPTH(`IMAGE_FIFO_DEPTH)) u_fifo (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .inValid  (push),
        .inReady  (fifoReady),
        .inData   (s.dataS2),
        .outValid (imageValid),
        .outReady (imageReady),
        .outData  (imageData)
    );

    assign flashPins           = s.pins;
    assign initDoneOut         = 1'b0;
    assign initDoneOe          = s.initOe;
    assign internalConfigClock = s.iclk;
    assign extClockActive      = s.extAct;
    assign configDone          = s.st == ST_DONE;
    assign configError         = s.st == ST_FAIL;

    property p_mode_gate;
        @(posedge ref_clk) disable iff (srst)
        (s.st == ST_INIT && $past(s.st) == ST_IDLE) |-> $past(s.modeS2) == `MODE_PAR_FLASH;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("init without mode 010");

    property p_read_pins;
        @(posedge ref_clk) disable iff (srst)
        (s.st == ST_HDR) |-> !s.pins.chipSelN && !s.pins.outEnN && !s.pins.addrValidN
                             && !s.initOe;
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("header read pins wrong");

    property p_hdr_internal;
        @(posedge ref_clk) disable iff (srst)
        (s.st == ST_HDR || s.st == ST_HDRX) |-> !s.extAct;
    endproperty
    a_hdr_internal: assert property (p_hdr_internal) else $error("header on external clock");

    property p_rcr_write;
        @(posedge ref_clk) disable iff (srst)
        (s.st == ST_RCR && s.phase == 2'h0 && tickI) |=> !s.pins.writeEnN
            && s.pins.dataOut == `CMD_RCR_SETUP
            && s.pins.addr == ($past(syncTypeSel) ? `RCR_TYPE2 : `RCR_TYPE1);
    endproperty
    a_rcr_write: assert property (p_rcr_write) else $error("rcr setup write wrong");

    property p_resume;
        @(posedge ref_clk) disable iff (srst)
        (s.st == ST_HDRX && $past(s.st) == ST_RCR) |-> $past(s.phase) == 2'h3
            && s.pins.writeEnN && s.syncMode;
    endproperty
    a_resume: assert property (p_resume) else $error("header resumed early");

    property p_ext_rate;
        @(posedge ref_clk) disable iff (srst)
        (push && s.extAct) |-> s.emcS2 && !s.emcS3 && s.syncMode;
    endproperty
    a_ext_rate: assert property (p_ext_rate) else $error("word off external edge");

    property p_int_rate;
        @(posedge ref_clk) disable iff (srst)
        (push && !s.extAct) |=> !push [*2];
    endproperty
    a_int_rate: assert property (p_int_rate) else $error("internal rate exceeded");

    property p_stay_sync;
        @(posedge ref_clk) disable iff (srst)
        (s.st == ST_DONE && s.rstS2) |=> s.pins.writeEnN && s.syncMode == $past(s.syncMode);
    endproperty
    a_stay_sync: assert property (p_stay_sync) else $error("flash mode touched after load");

    property p_restart;
        @(posedge ref_clk) disable iff (srst)
        !s.rstS2 |=> s.st == ST_IDLE && s.initOe;
    endproperty
    a_restart: assert property (p_restart) else $error("restart ignored");

    property p_addr_step;
        @(posedge ref_clk) disable iff (srst)
        push |=> s.rdAddr == $past(s.rdAddr) + 29'h1;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address step not one");
endmodule // parallel_flash_config_reader

// ### src/flash_cfg_defines.svh
// constants of the parallel flash configuration reader
// assumes a 200 MHz ref_clk and an x16 parallel NOR flash behind the pins
`ifndef FLASH_CFG_DEFINES_SVH
`define FLASH_CFG_DEFINES_SVH

`define REF_CLK_MHZ        200
`define REF_CLK_PERIOD_NS  5
`define ICLK_KHZ           3000
`define ICLK_DIV           ((`REF_CLK_MHZ * 1000) / `ICLK_KHZ)
`define INIT_TIME_NS       1000
`define INIT_CYCLES        ((`INIT_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define MODE_PAR_FLASH     3'h2
`define HDR_SYNC_KEY       16'ha55a
`define HDR_EXT_CLK_BIT    0
`define CMD_RCR_SETUP      16'h0060
`define CMD_RCR_CONFIRM    16'h0003
`define RCR_TYPE1          29'h0000_f94f
`define RCR_TYPE2          29'h0000_b94f
`define SYNC_LATENCY       4'h4
`define IMAGE_FIFO_DEPTH   16

`endif

// ### src/flash_cfg_pkg.sv
// types shared by the configuration reader, the flash model and the bench
// assumes nothing beyond the defines header
package flash_cfg_pkg;
    // loader sequence, gray coded along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_INIT = 3'h1,
        ST_HDR  = 3'h3,
        ST_RCR  = 3'h2,
        ST_HDRX = 3'h6,
        ST_DATA = 3'h7,
        ST_DONE = 3'h5,
        ST_FAIL = 3'h4
    } cfg_state_t;

    // everything driven toward the flash
    typedef struct packed {
        logic [28:0] addr;        // word address
        logic        chipSelN;    // flash_chip_select_n
        logic        outEnN;      // flash_output_enable_n
        logic        addrValidN;  // flash_address_valid_n
        logic        writeEnN;    // write strobe for the read config register
        logic        clk;         // burst clock toward the flash
        logic [15:0] dataOut;     // write data
        logic        dataOe;      // high while driving the data bus
    } flash_pins_t;
endpackage

// ### src/image_fifo.sv
// small flop based FIFO for configuration image words
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module image_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;  // storage
        logic [AW-1:0]               wp;   // write pointer
        logic [AW-1:0]               rp;   // read pointer
        logic [AW:0]                 cnt;  // words held
    } fifo_state_t;
    fifo_state_t s, n;
    logic push, pop;

    // full and empty come straight from the count
    assign inReady  = s.cnt != (AW+1)'(DEPTH);
    assign outValid = s.cnt != '0;
    assign outData  = s.mem[s.rp];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // next state of pointers and storage
    always_comb begin
        n = s;
        if (push) begin
            n.mem[s.wp] = inData;
            n.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
        end
        if (pop) begin
            n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
        end
        n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // register the state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule // image_fifo

// ### test/nor_flash_model.sv
// behavioural x16 parallel NOR flash holding the configuration image
// assumes the bench loads mem and treats powerOff as the flash supply cut
`timescale 1ns/1ps
`include "flash_cfg_defines.svh"
module nor_flash_model (
    input  wire logic                       ref_clk,
    input  wire logic                       powerOff,
    input  wire flash_cfg_pkg::flash_pins_t pins,
    input  wire logic [15:0]                dataBus,
    output logic [15:0]                     dataDrive,
    output logic [28:0]                     rcrValue,
    output logic                            syncMode,
    output logic [3:0]                      rcrWrites
);
    import flash_cfg_pkg::*;
    logic [15:0] mem [0:63];          // image words, filled by the bench
    logic [15:0] lastQ = 16'h5a5a;    // last word read
    logic [15:0] dataQ;               // bus value while the strobe is low
    logic        weQ;                 // strobe one cycle ago
    logic        setupQ;              // setup command seen
    logic [28:0] addrQ;               // address held while the strobe is low
    wire         reading = !pins.chipSelN && !pins.outEnN && pins.writeEnN;
    // word index is the device address; the offset wiring sits on the board
    // a released bus shows the inverse of the last word, never a stale copy
    assign dataDrive = reading ? mem[pins.addr[5:0]] : ~lastQ;
    // async command writes latch on the rising strobe; sync mode survives until power off
    always @(posedge ref_clk) begin
        weQ <= pins.writeEnN;
        if (reading)
            lastQ <= mem[pins.addr[5:0]];
        if (!pins.writeEnN) begin
            dataQ <= dataBus;
            addrQ <= pins.addr;
        end
        if (powerOff) begin
            syncMode  <= 1'b0;
            setupQ    <= 1'b0;
            rcrWrites <= 4'h0;
            rcrValue  <= 29'h0;
        end else if (!pins.chipSelN && pins.writeEnN && !weQ) begin
            if (dataQ == `CMD_RCR_SETUP) begin
                setupQ <= 1'b1;
            end else if (setupQ && dataQ == `CMD_RCR_CONFIRM) begin
                rcrValue  <= addrQ;
                syncMode  <= 1'b1;
                rcrWrites <= rcrWrites + 4'h1;
                setupQ    <= 1'b0;
            end else begin
                setupQ <= 1'b0;
            end
        end
    end
endmodule // nor_flash_model

// ### test/parallel_flash_config_reader_tb.sv
// self-checking bench for the parallel flash configuration reader
// assumes the flash model beside it and a pull-up on the init-done wire
`timescale 1ns/1ps
`include "flash_cfg_defines.svh"
module parallel_flash_config_reader_tb;
    import flash_cfg_pkg::*;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  modePins = 3'h2;
    logic        configRestartN = 1'b1;
    logic        syncTypeSel = 1'b0;
    logic        extClk = 1'b0;
    logic        imageReady = 1'b1;
    logic [1:0]  readyMode = 2'h0;     // 0 ready, 1 stalled, 2 random
    logic        initDoneOut, initDoneOe, intClk, imageValid, extClockActive;
    logic        configDone, configError, readPrev;
    logic [15:0] flashDataIn, flashDrive, imageData;
    logic [28:0] rcrValue, addrPrev;
    logic        syncMode;
    logic [3:0]  rcrWrites;
    flash_pins_t flashPins;
    logic [15:0] expQ [$];             // words still owed by the stream
    int          failures = 0;
    int          checks = 0;
    int          iclkRises = 0;        // rising edges of the internal clock
    int          iclkMark;             // edge count at reset release
    logic        iclkPrev;
    int          code;
    wire         initDoneIn = !(initDoneOe && !initDoneOut);
    wire         reading = !flashPins.chipSelN && !flashPins.outEnN && flashPins.writeEnN;
    // shared data wire: the loader wins while it drives
    assign flashDataIn = flashPins.dataOe ? flashPins.dataOut : flashDrive;

    always #2.5 ref_clk = ~ref_clk;
    // free running oscillator near 40 MHz, well under the burst limit
    always #12.3 extClk = ~extClk;
    // consumer side of the stream
    always @(negedge ref_clk)
        imageReady <= (readyMode == 2'h0) || (readyMode == 2'h2 && $urandom_range(1) == 1);

    parallel_flash_config_reader parallel_flash_config_reader_inst (
        .ref_clk(ref_clk), .srst(srst), .modePins(modePins),
        .configRestartN(configRestartN), .initDoneIn(initDoneIn),
        .initDoneOut(initDoneOut), .initDoneOe(initDoneOe), .syncTypeSel(syncTypeSel),
        .externalMasterConfigClock(extClk), .flashDataIn(flashDataIn),
        .flashPins(flashPins), .internalConfigClock(intClk), .imageData(imageData),
        .imageValid(imageValid), .imageReady(imageReady),
        .extClockActive(extClockActive), .configDone(configDone),
        .configError(configError));

    nor_flash_model nor_flash_model_inst (
        .ref_clk(ref_clk), .powerOff(srst), .pins(flashPins), .dataBus(flashDataIn),
        .dataDrive(flashDrive), .rcrValue(rcrValue), .syncMode(syncMode),
        .rcrWrites(rcrWrites));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // bounded wait: 0 init-done pull, 1 chip select, 2 done
    task automatic wait_sig(input int sel, input logic val, input int limit);
        int n;
        n = 0;
        while (n < limit && (sel == 0 ? initDoneOe : sel == 1 ? flashPins.chipSelN
                             : configDone) !== val) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == limit)
            check(32'h0, 32'h1);
    endtask

    // kind: 0 plain, 1 consumer stall, 2 restart pulse during the header
    task automatic run_image(input logic keyOn, input logic extSel, input logic typeSel,
                             input int len, input int kind);
        int i;
        srst = 1'b1;
        syncTypeSel = typeSel;
        readyMode = (kind == 1) ? 2'h1 : 2'h0;
        // image laid out x16 upward from word zero
        nor_flash_model_inst.mem[0] = keyOn ? `HDR_SYNC_KEY : 16'h0123;
        nor_flash_model_inst.mem[1] = {15'h0, extSel};
        nor_flash_model_inst.mem[2] = 16'h0;
        nor_flash_model_inst.mem[3] = len[15:0];
        for (i = 0; i < len; i++) begin
            nor_flash_model_inst.mem[4 + i] = 16'($urandom);
            expQ.push_back(nor_flash_model_inst.mem[4 + i]);
        end
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        wait_sig(0, 1'b0, 2000);
        check(flashPins.chipSelN, 1'b1);
        check(initDoneOut, 1'b0);
        wait_sig(1, 1'b0, 1000);
        check({flashPins.addr, flashPins.outEnN, flashPins.addrValidN}, 32'h0);
        if (kind == 2) begin
            configRestartN = 1'b0;
            repeat (10) @(negedge ref_clk);
            check({initDoneOe, flashPins.chipSelN}, 32'h3);
            configRestartN = 1'b1;
            wait_sig(0, 1'b0, 2000);
            wait_sig(1, 1'b0, 1000);
            check(flashPins.addr, 32'h0);
        end
        if (kind == 1) begin
            // long enough to fill the buffer and hit its refusal
            repeat (3000) @(negedge ref_clk);
            check(imageValid, 1'b1);
            readyMode = 2'h2;
        end
        wait_sig(2, 1'b1, 40000);
        i = 0;
        while (expQ.size() > 0 && i < 300) begin
            @(negedge ref_clk);
            i++;
        end
        check(expQ.size(), 32'h0);
        check(imageValid, 1'b0);
        check(extClockActive, keyOn & extSel);
        check(rcrWrites, keyOn ? 32'h1 : 32'h0);
        if (keyOn) begin
            check(rcrValue, typeSel ? `RCR_TYPE2 : `RCR_TYPE1);
            check(syncMode, 1'b1);
        end
        $display("test done: key %0b ext %0b type %0b len %0d kind %0d",
                 keyOn, extSel, typeSel, len, kind);
    endtask

    // stream scoreboard and flash pin watch
    always @(posedge ref_clk) begin
        if (!srst && imageValid === 1'b1 && imageReady === 1'b1) begin
            if (expQ.size() == 0)
                check(32'h1, 32'h0);
            else
                check(imageData, expQ.pop_front());
        end
        if (!srst && readPrev && reading && flashPins.addr !== addrPrev)
            check(flashPins.addr, addrPrev + 29'h1);
        if (!srst && !flashPins.outEnN && flashPins.dataOe)
            check(32'h1, 32'h0);
        // burst clock only once the flash holds the synchronous setting
        if (!srst && flashPins.clk && !syncMode)
            check(32'h1, 32'h0);
        if (!srst && intClk && !iclkPrev)
            iclkRises++;
        iclkPrev <= intClk;
        readPrev <= reading;
        addrPrev <= flashPins.addr;
    end

    initial begin
        void'($urandom(40));
        // every other mode code must leave the flash alone
        for (code = 0; code < 8; code++) begin
            if (code != 2) begin
                srst = 1'b1;
                modePins = code[2:0];
                repeat (10) @(negedge ref_clk);
                srst = 1'b0;
                iclkMark = iclkRises;
                repeat (300) @(negedge ref_clk);
                check({configError, flashPins.chipSelN}, 32'h3);
                // first rise half a period in, then one per 66 cycles
                check(iclkRises - iclkMark, 32'd5);
            end
        end
        $display("test done: mode codes");
        modePins = 3'h2;
        // internal 3 MHz rate stays within the async limit
        run_image(1'b0, 1'b0, 1'b0, 6, 0);
        run_image(1'b0, 1'b1, 1'b0, 20, 1);
        run_image(1'b1, 1'b1, 1'b0, 24, 0);
        run_image(1'b1, 1'b0, 1'b1, 5, 2);
        print_verdict();
    end

    // cuts a hang short
    initial begin
        repeat (99000) @(posedge ref_clk);
        failures++;
        $display("BAD at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule // parallel_flash_config_reader_tb
